// ==== include/xbus_irq_defs.svh ====
// Register offsets, field positions, reset values and trap constants.
`ifndef XBUS_IRQ_DEFS_SVH
`define XBUS_IRQ_DEFS_SVH

`define XIRQ_ROUTE0_OFS 8'h00
`define XIRQ_ROUTE1_OFS 8'h04
`define XIRQ_ROUTE2_OFS 8'h08
`define XIRQ_ROUTE3_OFS 8'h0c
`define XIRQ_TRAPFLAG_OFS 8'h10
`define XIRQ_TRAPSTAT_OFS 8'h14

`define XIRQ_EN_MSB 15
`define XIRQ_EN_LSB 8
`define XIRQ_FLAG_MSB 7
`define XIRQ_FLAG_LSB 0
`define XIRQ_ROUTE_RST 16'h0000
`define XIRQ_TRAPFLAG_RST 9'h000

`define SRC_CAN_UNIT_1 0
`define SRC_CAN_UNIT_2 1
`define SRC_I2C_RX 2
`define SRC_I2C_TX 3
`define SRC_I2C_ERR 4
`define SRC_SYNC_SERIAL_UNIT_1_RX 5
`define SRC_SYNC_SERIAL_UNIT_1_TX 6
`define SRC_SYNC_SERIAL_UNIT_1_ERR 7
`define SRC_ASYNC_SERIAL_UNIT_1_RX 8
`define SRC_ASYNC_SERIAL_UNIT_1_TX 9
`define SRC_ASYNC_SERIAL_UNIT_1_TBUF 10
`define SRC_ASYNC_SERIAL_UNIT_1_ERR 11
`define SRC_PLL_OWD 12
`define SRC_PWM2_CH3 13
`define SRC_COUNT 14

`define TF_NMI 0
`define TF_STACK_OVERFLOW_FLAG 1
`define TF_STACK_UNDERFLOW_FLAG 2
`define TF_B_LSB 3
`define TF_B_MSB 8

`define TRAP_RESET_LOC 24'h000000
`define TRAP_NMI_LOC 24'h000008
`define TRAP_STO_LOC 24'h000010
`define TRAP_STU_LOC 24'h000018
`define TRAP_B_LOC 24'h000028
`define TRAP_RESET_NUM 8'h00
`define TRAP_NMI_NUM 8'h02
`define TRAP_STO_NUM 8'h04
`define TRAP_STU_NUM 8'h06
`define TRAP_B_NUM 8'h0a
`define TRAP_ILVL_MAX 4'hf
`define TRAP_ILVL_MIN 4'h0

`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// ==== include/xbus_irq_pkg.sv ====
// Types shared by the extension-bus interrupt multiplexer and trap arbiter.
package xbus_irq_pkg;
	typedef enum logic [3:0] {
		LVL_NONE = 4'b0001,
		LVL_B = 4'b0010,
		LVL_A = 4'b0100,
		LVL_RST = 4'b1000
	} trap_lvl_t;
	typedef logic [13:0] src_vec_t;
	typedef logic [7:0] route_byte_t;
endpackage

// ==== include/trap_req_if.sv ====
// Carrier between the register block and the trap priority arbiter.
`timescale 1ns/1ps
interface trap_req_if;
	import xbus_irq_pkg::*;
	logic evReset;
	logic [2:0] evA;
	logic evB;
	logic taken;
	logic done;
	logic valid;
	logic [23:0] vector;
	logic [7:0] number;
	trap_lvl_t level;
	logic busy;
	modport regs (output evReset, evA, evB, taken, done,
		input valid, vector, number, level, busy);
	modport arb (input evReset, evA, evB, taken, done,
		output valid, vector, number, level, busy);
endinterface

// ==== design/trap_prio_arbiter.sv ====
// Hardware trap priority arbiter with a small preemption stack.
`timescale 1ns/1ps
`include "xbus_irq_defs.svh"
module trap_prio_arbiter (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	trap_req_if.arb tr
);
	import xbus_irq_pkg::*;

	logic pendRst;
	logic [2:0] pendA;
	logic pendB;
	trap_lvl_t cur;
	trap_lvl_t saved [0:1];
	logic [1:0] sp;
	trap_lvl_t topLvl;
	logic [2:0] topA;
	logic [2:0] presA;
	logic takeNow;

	always_comb begin
		topA = 3'b000;
		if (pendA[0])
			topA = 3'b001;
		else if (pendA[1])
			topA = 3'b010;
		else if (pendA[2])
			topA = 3'b100;
		if (pendRst)
			topLvl = LVL_RST;
		else if (|pendA)
			topLvl = LVL_A;
		else if (pendB)
			topLvl = LVL_B;
		else
			topLvl = LVL_NONE;
	end

	assign takeNow = tr.taken && tr.valid;

	// Hardware reset leaves a reset service pending; events win over clears.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pendRst <= 1'b1;
			pendA <= 3'b000;
			pendB <= 1'b0;
		end else if (ce) begin
			pendRst <= (pendRst && !(takeNow && tr.level == LVL_RST))
				|| tr.evReset;
			pendA <= (pendA & ~((takeNow && tr.level == LVL_A) ? presA :
				3'b000)) | tr.evA;
			pendB <= (pendB && !(takeNow && tr.level == LVL_B)) || tr.evB;
		end
	end

	// Only a strictly higher class is offered while a service runs.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tr.valid <= 1'b0;
			tr.level <= LVL_NONE;
			tr.vector <= `TRAP_RESET_LOC;
			tr.number <= `TRAP_RESET_NUM;
			presA <= 3'b000;
		end else if (ce) begin
			tr.valid <= (topLvl > cur) && !takeNow;
			tr.level <= topLvl;
			presA <= topA;
			case (topLvl)
				LVL_RST: begin
					tr.vector <= `TRAP_RESET_LOC;
					tr.number <= `TRAP_RESET_NUM;
				end
				LVL_A: begin
					tr.vector <= topA[0] ? `TRAP_NMI_LOC :
						topA[1] ? `TRAP_STO_LOC : `TRAP_STU_LOC;
					tr.number <= topA[0] ? `TRAP_NMI_NUM :
						topA[1] ? `TRAP_STO_NUM : `TRAP_STU_NUM;
				end
				LVL_B: begin
					tr.vector <= `TRAP_B_LOC;
					tr.number <= `TRAP_B_NUM;
				end
				default: begin
					tr.vector <= `TRAP_RESET_LOC;
					tr.number <= `TRAP_RESET_NUM;
				end
			endcase
		end
	end

	// Only two levels, idle included, are saved below the running one.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cur <= LVL_NONE;
			saved[0] <= LVL_NONE;
			saved[1] <= LVL_NONE;
			sp <= 2'd0;
			tr.busy <= 1'b0;
		end else if (ce) begin
			if (takeNow) begin
				cur <= tr.level;
				if (sp < 2'd2) begin
					saved[sp[0]] <= cur;
					sp <= sp + 2'd1;
				end
				tr.busy <= 1'b1;
			end else if (tr.done && cur != LVL_NONE) begin
				if (sp != 2'd0) begin
					cur <= saved[sp[0] ^ 1'b1];
					sp <= sp - 2'd1;
					tr.busy <= saved[sp[0] ^ 1'b1] != LVL_NONE;
				end else begin
					cur <= LVL_NONE;
					tr.busy <= 1'b0;
				end
			end
		end
	end
endmodule

// ==== design/xbus_irq_mux.sv ====
// Extension-bus interrupt routing registers, trap flags and AXI4-Lite slave.
// Function
// - Four 16-bit routing registers, one per shared vector, same structure.
// - Upper byte holds per-source enables gating the shared vector.
// - Lower byte holds per-source flags recording peripheral events.
// - Vector requests when any source has both flag and enable set.
// - Flags set on events even while the enable bit is clear.
// - Serial, I2C and CAN sources route to vectors per fixed table.
// - PLL/oscillator watchdog to vector 3; pulse unit ch3 to 2 and 3.
// - All resets use location 0, trap 0, highest priority.
// - Class A traps: second level, own vectors 08h, 10h, 18h.
// - Class B traps share location 28h, trap 0Ah, lowest level.
// - CPU priority forced to 15 while any trap is serviced.
// - Each hardware trap except reset sets its own bit in the trap flag register.
// - Trap service blocks standard interrupts; only higher traps preempt.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "xbus_irq_defs.svh"
module xbus_irq_mux #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire xbus_irq_pkg::src_vec_t srcEvent,
	input wire logic swResetEvent,
	input wire logic watchdogOverflowEvent,
	input wire logic nmiEvent,
	input wire logic stackOverflowEvent,
	input wire logic stackUnderflowEvent,
	input wire logic [5:0] classBEvent,
	input wire logic trapTaken,
	input wire logic trapDone,
	output logic [3:0] sharedVector,
	output logic trapValid,
	output logic [23:0] trapVector,
	output logic [7:0] trapNumber,
	output xbus_irq_pkg::trap_lvl_t trapLevel,
	output logic trapBusy,
	output logic cpuPriorityForce,
	output logic [3:0] cpuPriorityLevel
);
	import xbus_irq_pkg::*;

	localparam logic [2:0] IDX_NONE = 3'd7;

	logic [15:0] route [0:3];
	logic [8:0] trapFlag;
	logic [ADDR_W-1:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic doWrite;
	logic [2:0] wrIdx;
	logic [2:0] rdIdx;
	logic [31:0] next_rdata;
	logic [8:0] trapEvents;
	trap_req_if tr ();

	// Bit position of each source inside a vector's byte.
	function automatic route_byte_t routeEvents(input logic [1:0] vec,
		input src_vec_t ev);
		route_byte_t r;
		r = 8'h00;
		case (vec)
			2'd0: r[0] = ev[`SRC_CAN_UNIT_1];
			2'd1: r[0] = ev[`SRC_CAN_UNIT_2];
			2'd2: r[0] = ev[`SRC_PWM2_CH3];
			default: r[0] = ev[`SRC_CAN_UNIT_1];
		endcase
		if (vec != 2'd3) begin
			r[1] = ev[`SRC_I2C_RX];
			r[2] = ev[`SRC_I2C_TX];
			r[3] = ev[`SRC_SYNC_SERIAL_UNIT_1_RX];
			r[4] = ev[`SRC_SYNC_SERIAL_UNIT_1_TX];
			r[5] = ev[`SRC_ASYNC_SERIAL_UNIT_1_RX];
			r[6] = ev[`SRC_ASYNC_SERIAL_UNIT_1_TX];
			r[7] = ev[`SRC_ASYNC_SERIAL_UNIT_1_TBUF];
		end else begin
			r[1] = ev[`SRC_CAN_UNIT_2];
			r[2] = ev[`SRC_I2C_ERR];
			r[3] = ev[`SRC_SYNC_SERIAL_UNIT_1_ERR];
			r[4] = ev[`SRC_ASYNC_SERIAL_UNIT_1_ERR];
			r[5] = ev[`SRC_PLL_OWD];
			r[6] = ev[`SRC_PWM2_CH3];
		end
		return r;
	endfunction

	// Register index for a byte address, IDX_NONE when unmapped.
	function automatic logic [2:0] regIndex(input logic [ADDR_W-1:0] a);
		logic [2:0] idx;
		idx = IDX_NONE;
		if ((a >> 8) == '0) begin
			case (a[7:0])
				`XIRQ_ROUTE0_OFS: idx = 3'd0;
				`XIRQ_ROUTE1_OFS: idx = 3'd1;
				`XIRQ_ROUTE2_OFS: idx = 3'd2;
				`XIRQ_ROUTE3_OFS: idx = 3'd3;
				`XIRQ_TRAPFLAG_OFS: idx = 3'd4;
				`XIRQ_TRAPSTAT_OFS: idx = 3'd5;
				default: idx = IDX_NONE;
			endcase
		end
		return idx;
	endfunction

	// Address and data are taken independently and written once both sit.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_awready <= 1'b1;
			wrAddr <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				wrAddr <= s_axi_awaddr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_wready <= 1'b1;
			wrData <= 32'h00000000;
			wrStrb <= 4'h0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wrData <= s_axi_wdata;
				wrStrb <= s_axi_wstrb;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wrIdx = regIndex(wrAddr);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AXI_RESP_OKAY;
		end else if (ce) begin
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wrIdx == IDX_NONE) ? `AXI_RESP_SLVERR :
					`AXI_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// One loop body per vector: the structure is identical for all four.
	for (genvar v = 0; v < 4; v++) begin : g_route
		logic [1:0] vecId;
		route_byte_t ev;
		route_byte_t valid;
		route_byte_t clr;
		logic hit;
		assign vecId = 2'(v);
		assign ev = routeEvents(vecId, srcEvent);
		// Unrouted positions stay zero in both bytes.
		assign valid = routeEvents(vecId, '1);
		assign hit = doWrite && wrIdx == 3'(v);
		// Writing one to a flag clears it.
		assign clr = (hit && wrStrb[0]) ? wrData[7:0] : 8'h00;

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				route[v][`XIRQ_EN_MSB:`XIRQ_EN_LSB] <=
					route_byte_t'(`XIRQ_ROUTE_RST >> `XIRQ_EN_LSB);
			end else if (ce && hit && wrStrb[1]) begin
				route[v][`XIRQ_EN_MSB:`XIRQ_EN_LSB] <=
					wrData[15:8] & valid;
			end
		end

		// Events set flags whatever the enables say, and win over a clear.
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				route[v][`XIRQ_FLAG_MSB:`XIRQ_FLAG_LSB] <=
					route_byte_t'(`XIRQ_ROUTE_RST);
			end else if (ce) begin
				route[v][`XIRQ_FLAG_MSB:`XIRQ_FLAG_LSB] <=
					(route[v][`XIRQ_FLAG_MSB:`XIRQ_FLAG_LSB] & ~clr)
					| ev;
			end
		end

		// Standard requests are held back while a trap runs.
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				sharedVector[v] <= 1'b0;
			end else if (ce) begin
				sharedVector[v] <= |(route[v][`XIRQ_EN_MSB:`XIRQ_EN_LSB]
					& route[v][`XIRQ_FLAG_MSB:`XIRQ_FLAG_LSB])
					&& !tr.busy;
			end
		end
	end

	assign trapEvents = {classBEvent, stackUnderflowEvent,
		stackOverflowEvent, nmiEvent};

	// Each trap leaves its own sticky bit; resets leave none.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trapFlag <= `XIRQ_TRAPFLAG_RST;
		end else if (ce) begin
			trapFlag <= (trapFlag & ~((doWrite && wrIdx == 3'd4 &&
				wrStrb[0]) ? {wrStrb[1] & wrData[8], wrData[7:0]} :
				9'h000)) | trapEvents;
		end
	end

	assign rdIdx = regIndex(s_axi_araddr);

	always_comb begin
		next_rdata = 32'h00000000;
		case (rdIdx)
			3'd0: next_rdata[15:0] = route[0];
			3'd1: next_rdata[15:0] = route[1];
			3'd2: next_rdata[15:0] = route[2];
			3'd3: next_rdata[15:0] = route[3];
			3'd4: next_rdata[8:0] = trapFlag;
			3'd5: begin
				next_rdata[0] = tr.busy;
				next_rdata[1] = tr.valid;
				next_rdata[7:4] = tr.level;
				next_rdata[15:8] = tr.number;
			end
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AXI_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= (rdIdx == IDX_NONE) ? `AXI_RESP_SLVERR :
					`AXI_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	assign tr.evReset = swResetEvent || watchdogOverflowEvent;
	assign tr.evA = {stackUnderflowEvent, stackOverflowEvent, nmiEvent};
	assign tr.evB = |classBEvent;
	assign tr.taken = trapTaken;
	assign tr.done = trapDone;

	trap_prio_arbiter u_arb (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.tr(tr)
	);

	// Trap outputs are re-timed here so every port leaves a local flop.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trapValid <= 1'b0;
			trapVector <= `TRAP_RESET_LOC;
			trapNumber <= `TRAP_RESET_NUM;
			trapLevel <= LVL_NONE;
			trapBusy <= 1'b0;
		end else if (ce) begin
			trapValid <= tr.valid && !trapTaken;
			trapVector <= tr.vector;
			trapNumber <= tr.number;
			trapLevel <= tr.level;
			trapBusy <= tr.busy;
		end
	end

	// The priority force follows the service flag with one flop of delay.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cpuPriorityForce <= 1'b0;
			cpuPriorityLevel <= `TRAP_ILVL_MIN;
		end else if (ce) begin
			cpuPriorityForce <= tr.busy;
			cpuPriorityLevel <= tr.busy ? `TRAP_ILVL_MAX : `TRAP_ILVL_MIN;
		end
	end
endmodule

// ==== dv/xbus_irq_mux_props.sv ====
// Checker for trap offers, priority forcing and shared vector masking.
`timescale 1ns/1ps
module xbus_irq_mux_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic nmiEvent,
	input wire logic trapTaken,
	input wire logic s_axi_bvalid,
	input wire logic [3:0] sharedVector,
	input wire logic trapValid,
	input wire logic [23:0] trapVector,
	input wire logic [7:0] trapNumber,
	input wire xbus_irq_pkg::trap_lvl_t trapLevel,
	input wire logic trapBusy,
	input wire logic cpuPriorityForce,
	input wire logic [3:0] cpuPriorityLevel
);
	import xbus_irq_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	force_busy_a: assert property (
		trapBusy |-> cpuPriorityForce && cpuPriorityLevel == 4'hf)
		else $error("priority not forced in trap");
	reset_vec_a: assert property (
		trapValid && trapLevel == LVL_RST |-> {trapVector, trapNumber} == 32'h0)
		else $error("reset trap vector wrong");
	class_a_a: assert property (
		trapValid && trapLevel == LVL_A |-> {trapVector, trapNumber}
		inside {32'h00000802, 32'h00001004, 32'h00001806})
		else $error("class A vector wrong");
	class_b_a: assert property (
		trapValid && trapLevel == LVL_B |-> {trapVector, trapNumber} == 32'h280a)
		else $error("class B vector wrong");
	taken_busy_a: assert property (
		trapValid && trapTaken |=> !trapValid ##1 trapBusy)
		else $error("taken trap not serviced");
	mask_busy_a: assert property (
		trapBusy [*2] |-> sharedVector == 4'h0)
		else $error("vector active in trap");
	nmi_offer_a: assert property (
		nmiEvent && !trapBusy && !trapValid |-> ##3 trapValid && trapLevel == LVL_A)
		else $error("nmi not offered");
	fall_write_a: assert property (
		|($past(sharedVector) & ~sharedVector) |-> $past(s_axi_bvalid)
		|| trapBusy || $past(trapBusy) || $past(trapTaken) || $past(trapTaken, 2))
		else $error("vector fell without write");
	cover property (trapValid && trapLevel == LVL_A && trapBusy);
	cover property (trapTaken && trapValid && trapLevel == LVL_RST);
	cover property (sharedVector[3] && sharedVector[2]);
endmodule

// ==== dv/cpu_trap_model.sv ====
// CPU side model that takes offered traps and returns after a while.
`timescale 1ns/1ps
module cpu_trap_model #(
	parameter int HOLD = 12
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic trapValid,
	output logic trapTaken,
	output logic trapDone
);
	int depth;
	int timer;
	// Any offer is taken, so a higher class nests over a running one.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trapTaken <= 1'b0;
		end else begin
			trapTaken <= trapValid && !trapTaken;
		end
	end
	// Returns are not raised in a cycle that sees a take, but can still meet the next take, which the design would drop.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			depth <= 0;
			timer <= 0;
			trapDone <= 1'b0;
		end else begin
			trapDone <= 1'b0;
			if (trapTaken) begin
				depth <= depth + 1;
				timer <= HOLD;
			end else if (depth > 0 && timer == 0 && !trapDone) begin
				trapDone <= 1'b1;
				depth <= depth - 1;
				timer <= HOLD;
			end else if (timer > 0) begin
				timer <= timer - 1;
			end
		end
	end
endmodule

// ==== dv/tb_xbus_irq_mux.sv ====
// Self-checking bench for the interrupt multiplexer and trap arbiter.
`timescale 1ns/1ps
module tb_xbus_irq_mux;
	import xbus_irq_pkg::*;
	logic clk, rstn, ce, trapTaken, trapDone, trapValid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, trapNumber;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, sharedVector, cpuPriorityLevel;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, trapBusy, cpuPriorityForce;
	src_vec_t srcEvent;
	logic [10:0] trapEv;
	logic [23:0] trapVector;
	trap_lvl_t trapLevel;
	int fail_count = 0;
	int checked = 0;
	// Expected flag bytes per source, route 3 in the top byte.
	localparam logic [31:0] ROUTE [14] = '{32'h01000001, 32'h02000100,
		32'h00020202, 32'h00040404, 32'h04000000, 32'h00080808,
		32'h00101010, 32'h08000000, 32'h00202020, 32'h00404040,
		32'h00808080, 32'h10000000, 32'h20000000, 32'h40010000};

	xbus_irq_mux xbus_irq_mux_inst (.clk, .rstn, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .srcEvent,
		.swResetEvent(trapEv[9]), .watchdogOverflowEvent(trapEv[10]),
		.nmiEvent(trapEv[0]), .stackOverflowEvent(trapEv[1]),
		.stackUnderflowEvent(trapEv[2]), .classBEvent(trapEv[8:3]),
		.trapTaken, .trapDone, .sharedVector, .trapValid, .trapVector,
		.trapNumber, .trapLevel, .trapBusy, .cpuPriorityForce,
		.cpuPriorityLevel);
	cpu_trap_model cpu_trap_model_inst (.clk, .rstn, .trapValid,
		.trapTaken, .trapDone);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// The wait ends on the answer; only the watchdog ends one that never comes.
		forever begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wait_eq(ref logic s, input logic v);
		for (int i = 0; i < 300 && s !== v; i++) @(posedge clk);
		if (s !== v) begin
			fail_count++;
			$display("mismatch wait expected %b seen %b", v, s);
		end
	endtask

	// A low clock enable must drop events and keep every flop still.
	task automatic test_hold;
		wr(8'h00, 32'h0100);
		@(posedge clk);
		ce <= 1'b0;
		srcEvent[0] <= 1'b1;
		@(posedge clk);
		srcEvent <= '0;
		repeat (2) @(posedge clk);
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		chk("hold vector", 32'h0, 32'(sharedVector));
		rd(8'h00);
		chk("hold flags", 32'h00000100, d);
		wr(8'h00, 32'h00ff);
		$display("test hold done");
	endtask

	task automatic fire(input int k);
		@(posedge clk);
		trapEv[k] <= 1'b1;
		@(posedge clk);
		trapEv <= '0;
	endtask

	task automatic test_regs;
		for (int i = 0; i < 4; i++) begin
			rd(8'(4 * i));
			chk("route reset", 32'h0, d);
		end
		wr(8'h0c, 32'h0000ff00);
		rd(8'h0c);
		chk("route3 enables", 32'h00007f00, d);
		wr(8'h18, 32'h0);
		chk("unmapped write", 32'h2, 32'(r));
		rd(8'h18);
		chk("unmapped read", 32'h2, 32'(r));
		wr(8'h0c, 32'h0);
		$display("test regs done");
	endtask

	task automatic test_route;
		for (int s = 0; s < 14; s++) begin
			@(posedge clk);
			srcEvent[s] <= 1'b1;
			@(posedge clk);
			srcEvent <= '0;
			repeat (2) @(posedge clk);
			chk("vector masked", 32'h0, 32'(sharedVector));
			for (int v = 0; v < 4; v++) begin
				rd(8'(4 * v));
				chk("flags", 32'(ROUTE[s][8*v+:8]), d);
				wr(8'(4 * v), 32'h0000ff00);
			end
			repeat (2) @(posedge clk);
			chk("vector", {28'h0, |ROUTE[s][31:24], |ROUTE[s][23:16],
				|ROUTE[s][15:8], |ROUTE[s][7:0]}, 32'(sharedVector));
			for (int v = 0; v < 4; v++) wr(8'(4 * v), 32'h000000ff);
		end
		$display("test route done");
	endtask

	task automatic test_preempt;
		wr(8'h00, 32'h0100);
		@(posedge clk);
		srcEvent[0] <= 1'b1;
		@(posedge clk);
		srcEvent <= '0;
		repeat (3) @(posedge clk);
		chk("vector before", 32'h1, 32'(sharedVector));
		fire(3);
		wait_eq(trapBusy, 1'b1);
		repeat (2) @(posedge clk);
		chk("vector in trap", 32'h0, 32'(sharedVector));
		fire(0);
		wait_eq(trapValid, 1'b1);
		chk("preempt", 32'h14, {trapBusy, trapLevel});
		wait_eq(trapBusy, 1'b0);
		wr(8'h00, 32'h00ff);
		wr(8'h10, 32'h1ff);
		$display("test preempt done");
	endtask

	task automatic test_traps;
		for (int k = 0; k < 11; k++) begin
			fire(k);
			wait_eq(trapValid, 1'b1);
			chk("trap", k < 3 ? {24'(8 * (k + 1)), 8'(2 * (k + 1))} :
				k < 9 ? 32'h280a : 32'h0, {trapVector, trapNumber});
			wait_eq(trapBusy, 1'b1);
			chk("priority", 32'h1f, {cpuPriorityForce, cpuPriorityLevel});
			wait_eq(trapBusy, 1'b0);
			if (k < 9) begin
				rd(8'h10);
				chk("trap flag", 32'(1 << k), d);
				wr(8'h10, 32'h1ff);
			end
		end
		$display("test traps done");
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		s_axi_wstrb = 4'hf;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		srcEvent = '0;
		trapEv = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		// Reset leaves a reset-class service pending; let it run out.
		wait_eq(trapBusy, 1'b1);
		wait_eq(trapBusy, 1'b0);
		test_regs();
		test_route();
		test_hold();
		test_preempt();
		test_traps();
		close_out();
	end

	initial begin
		#(40 * 20000);
		fail_count++;
		close_out();
	end
endmodule

bind xbus_irq_mux xbus_irq_mux_props xbus_irq_mux_props_inst (.clk, .rstn,
	.nmiEvent, .trapTaken, .s_axi_bvalid, .sharedVector, .trapValid,
	.trapVector, .trapNumber, .trapLevel, .trapBusy, .cpuPriorityForce,
	.cpuPriorityLevel);
